/* File: pkg/cpu_guard_regs.vh */
// Purpose: constants for the cpu register file and change guard
// Assumes: 8-bit cpu data bus, register offsets in i/o space
// Notes: window length counted in executed instructions
`ifndef CPU_GUARD_REGS_VH
`define CPU_GUARD_REGS_VH
`define GUARD_KEY_OFFSET 8'h04
`define GUARD_KEY_RESET 8'h00
`define IO_UNLOCK_KEY 8'hD8
`define SELFPROG_UNLOCK_KEY 8'h9D
`define GUARD_IO_BIT 0
`define GUARD_SP_BIT 1
`define GUARD_WINDOW_INSNS 3'h4
`define PTR_A_LOW 5'h1A
`define PTR_B_LOW 5'h1C
`define PTR_C_LOW 5'h1E
`define PTR_MODE_DISP 2'h0
`define PTR_MODE_POSTINC 2'h1
`define PTR_MODE_PREDEC 2'h2
`define TEMP_BYTE_RESET 8'h00
`endif

/* File: hw/gpr_array.v */
// Purpose: 32 by 8 working register array, two read ports, wide write
// Assumes: one clock, registered read data
// Notes: a 16-bit write to an even address goes to an even/odd pair; to an odd address only the low byte is written
`timescale 1ns/1ps
module gpr_array #(
    parameter NREG = 32
) (
    input wire mclk,
    input wire rst_b,
    input wire [4:0] rd_a_addr,
    input wire [4:0] rd_b_addr,
    output reg [15:0] rd_a_data,
    output reg [7:0] rd_b_data,
    input wire wr_en,
    input wire wr_wide,
    input wire [4:0] wr_addr,
    input wire [15:0] wr_data
);
    reg [7:0] mem [0:NREG-1];
    wire [4:0] rd_a_hi = {rd_a_addr[4:1], 1'b1};
    genvar i;
    generate
        for (i = 0; i < NREG; i = i + 1) begin : g_reg
            always @(posedge mclk or negedge rst_b) begin
                if (!rst_b) begin
                    mem[i] <= 8'h00;
                end else if (wr_en && wr_addr == i) begin
                    mem[i] <= wr_data[7:0];
                end else if (wr_en && wr_wide && {wr_addr[4:1], 1'b1} == i) begin
                    mem[i] <= wr_data[15:8];
                end
            end
        end
    endgenerate
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rd_a_data <= 16'h0000;
            rd_b_data <= 8'h00;
        end else begin
            rd_a_data <= {mem[rd_a_hi], mem[rd_a_addr]};
            rd_b_data <= mem[rd_b_addr];
        end
    end
endmodule

/* File: hw/cpu_regfile_wide_access_guard.v */
// Purpose: cpu register file, pointer pairs, 16-bit temp byte, change guard
// Assumes: cpu core drives ports on mclk; one instruction end pulse per insn
// Notes: register file is private to the core, never on the data bus
// How it works
// - thirty-two eight-bit registers, single cycle access
// - byte and word operand and result ports
// - registers 0x1A-0x1F form three pointers
// - lower address is pointer low byte
// - register file outside data address space
// - pointer displacement, post-increment, pre-decrement
// - program load, call, jump use pointer_c
// - low write to temp, high write commits
// - low read latches high into temp
// - temp byte directly readable and writable
// - protected actions need a valid key
// - io window closes on memory writes, sleep
// - selfprog window closes on nvm access, sleep
// - interrupts held off while window open
// - 0xD8 io key, 0x9D selfprog key
// - guard reads status bits 1:0 only
`timescale 1ns/1ps
`include "cpu_guard_regs.vh"
module cpu_regfile_wide_access_guard #(
    parameter NREG = 32
) (
    input wire mclk,
    input wire rst_b,
    input wire [4:0] rd_a_addr,
    input wire [4:0] rd_b_addr,
    output reg [15:0] opnd_a,
    output reg [7:0] opnd_b,
    input wire res_en,
    input wire res_wide,
    input wire [4:0] res_addr,
    input wire [15:0] res_data,
    input wire ptr_en,
    input wire [1:0] ptr_sel,
    input wire [1:0] ptr_mode,
    input wire [5:0] ptr_disp,
    input wire ptr_use_c,
    output reg [15:0] ptr_addr,
    input wire io_wr,
    input wire io_rd,
    input wire [7:0] io_addr,
    input wire [7:0] io_wdata,
    output reg [7:0] io_rdata,
    input wire wide_lo_wr,
    input wire wide_hi_wr,
    input wire wide_lo_rd,
    input wire wide_hi_rd,
    input wire temp_wr,
    input wire temp_rd,
    input wire [7:0] wide_hi_in,
    output reg [7:0] wide_lo_out,
    output reg [7:0] wide_hi_out,
    output reg wide_commit,
    input wire insn_done,
    input wire mem_wr,
    input wire nvm_access,
    input wire sleep_exec,
    output reg io_change_ok,
    output reg selfprog_ok,
    output reg irq_hold
);
    reg [7:0] temp_r;
    reg [2:0] io_cnt_r;
    reg [2:0] sp_cnt_r;
    reg [4:0] ptr_low;
    reg [15:0] ptr_val;
    reg [15:0] ptr_nxt;
    wire [15:0] arr_a;
    wire [7:0] arr_b;
    wire guard_wr = io_wr && io_addr == `GUARD_KEY_OFFSET;
    wire guard_rd = io_rd && io_addr == `GUARD_KEY_OFFSET;
    wire io_open = io_cnt_r != 3'h0;
    wire sp_open = sp_cnt_r != 3'h0;
    // pointer updates take priority over the result port, whatever register it addresses
    wire arr_wr = res_en || (ptr_en && ptr_mode != `PTR_MODE_DISP);
    wire arr_wide = (ptr_en && ptr_mode != `PTR_MODE_DISP) ? 1'b1 : res_wide;
    wire [4:0] arr_waddr = (ptr_en && ptr_mode != `PTR_MODE_DISP) ? ptr_low : res_addr;
    wire [15:0] arr_wdata = (ptr_en && ptr_mode != `PTR_MODE_DISP) ? ptr_nxt : res_data;
    reg [15:0] ptr_a_r, ptr_b_r, ptr_c_r;
    always @* begin
        ptr_low = `PTR_C_LOW;
        if (!ptr_use_c) begin
            case (ptr_sel)
                2'h0: ptr_low = `PTR_A_LOW;
                2'h1: ptr_low = `PTR_B_LOW;
                default: ptr_low = `PTR_C_LOW;
            endcase
        end
        case (ptr_low)
            `PTR_A_LOW: ptr_val = ptr_a_r;
            `PTR_B_LOW: ptr_val = ptr_b_r;
            default: ptr_val = ptr_c_r;
        endcase
        case (ptr_mode)
            `PTR_MODE_POSTINC: ptr_nxt = ptr_val + 16'h0001;
            `PTR_MODE_PREDEC: ptr_nxt = ptr_val - 16'h0001;
            default: ptr_nxt = ptr_val;
        endcase
    end
    // shadow copies of the pointer pairs track byte writes and even-address word writes to 0x1A-0x1F
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ptr_a_r <= 16'h0000;
            ptr_b_r <= 16'h0000;
            ptr_c_r <= 16'h0000;
        end else if (arr_wr) begin
            if ({arr_waddr[4:1], 1'b0} == `PTR_A_LOW)
                ptr_a_r <= upd(ptr_a_r);
            if ({arr_waddr[4:1], 1'b0} == `PTR_B_LOW)
                ptr_b_r <= upd(ptr_b_r);
            if ({arr_waddr[4:1], 1'b0} == `PTR_C_LOW)
                ptr_c_r <= upd(ptr_c_r);
        end
    end
    function [15:0] upd;
        input [15:0] old;
        begin
            if (arr_wide)
                upd = arr_wdata;
            else if (arr_waddr[0])
                upd = {arr_wdata[7:0], old[7:0]};
            else
                upd = {old[15:8], arr_wdata[7:0]};
        end
    endfunction
    // register file has its own ports; io_addr never reaches it
    gpr_array #(.NREG(NREG)) u_gpr (
        .mclk(mclk),
        .rst_b(rst_b),
        .rd_a_addr(rd_a_addr),
        .rd_b_addr(rd_b_addr),
        .rd_a_data(arr_a),
        .rd_b_data(arr_b),
        .wr_en(arr_wr),
        .wr_wide(arr_wide),
        .wr_addr(arr_waddr),
        .wr_data(arr_wdata)
    );
    always @* begin
        opnd_a = arr_a;
        opnd_b = arr_b;
    end
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ptr_addr <= 16'h0000;
        end else if (ptr_en) begin
            if (ptr_mode == `PTR_MODE_DISP)
                ptr_addr <= ptr_val + {10'h000, ptr_disp};
            else if (ptr_mode == `PTR_MODE_PREDEC)
                ptr_addr <= ptr_nxt;
            else
                ptr_addr <= ptr_val;
        end
    end
    // shared temp byte for 16-bit peripheral registers
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            temp_r <= `TEMP_BYTE_RESET;
            wide_lo_out <= 8'h00;
            wide_hi_out <= 8'h00;
            wide_commit <= 1'b0;
        end else begin
            wide_commit <= 1'b0;
            if (temp_wr || wide_lo_wr)
                temp_r <= io_wdata;
            else if (wide_lo_rd)
                temp_r <= wide_hi_in;
            if (wide_hi_wr) begin
                wide_hi_out <= io_wdata;
                wide_lo_out <= temp_r;
                wide_commit <= 1'b1;
            end
        end
    end
    // guard windows count down on instruction ends; a key write wins over closers
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            io_cnt_r <= 3'h0;
            sp_cnt_r <= 3'h0;
        end else begin
            if (guard_wr && io_wdata == `IO_UNLOCK_KEY)
                io_cnt_r <= `GUARD_WINDOW_INSNS;
            else if (guard_wr && io_wdata == `SELFPROG_UNLOCK_KEY)
                io_cnt_r <= 3'h0;
            else if ((io_wr && io_open) || mem_wr || nvm_access || sleep_exec)
                io_cnt_r <= 3'h0;
            else if (insn_done && io_open)
                io_cnt_r <= io_cnt_r - 3'h1;
            if (guard_wr && io_wdata == `SELFPROG_UNLOCK_KEY)
                sp_cnt_r <= `GUARD_WINDOW_INSNS;
            else if (guard_wr && io_wdata == `IO_UNLOCK_KEY)
                sp_cnt_r <= 3'h0;
            else if (nvm_access || sleep_exec)
                sp_cnt_r <= 3'h0;
            else if (insn_done && sp_open)
                sp_cnt_r <= sp_cnt_r - 3'h1;
        end
    end
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            io_rdata <= 8'h00;
            io_change_ok <= 1'b0;
            selfprog_ok <= 1'b0;
            irq_hold <= 1'b0;
        end else begin
            io_change_ok <= io_open;
            selfprog_ok <= sp_open;
            irq_hold <= io_open || sp_open || (guard_wr && (io_wdata == `IO_UNLOCK_KEY ||
                        io_wdata == `SELFPROG_UNLOCK_KEY));
            if (guard_rd)
                io_rdata <= {6'h00, sp_open, io_open};
            else if (temp_rd || wide_hi_rd)
                io_rdata <= temp_r;
            else
                io_rdata <= 8'h00;
        end
    end
endmodule

/* File: tb/cpu_guard_props.sv */
// Purpose: port assertions for the register file and change guard
// Assumes: one clock, strobes last one cycle
// Notes: bound to the top module
`timescale 1ns/1ps
`include "cpu_guard_regs.vh"
module cpu_guard_props (
    input wire mclk,
    input wire rst_b,
    input wire io_wr,
    input wire io_rd,
    input wire wide_lo_wr,
    input wire wide_hi_wr,
    input wire wide_lo_rd,
    input wire wide_hi_rd,
    input wire wide_commit,
    input wire mem_wr,
    input wire nvm_access,
    input wire sleep_exec,
    input wire io_change_ok,
    input wire selfprog_ok,
    input wire irq_hold,
    input wire [7:0] io_addr,
    input wire [7:0] io_wdata,
    input wire [7:0] io_rdata,
    input wire [7:0] wide_hi_in,
    input wire [7:0] wide_lo_out,
    input wire [7:0] wide_hi_out
);
default clocking @(posedge mclk); endclocking
default disable iff (!rst_b);
wire key = io_wr && io_addr == `GUARD_KEY_OFFSET;
wire iok = key && io_wdata == `IO_UNLOCK_KEY;
wire spk = key && io_wdata == `SELFPROG_UNLOCK_KEY;
property p_cmt; wide_lo_wr ##1 wide_hi_wr |=> wide_lo_out == $past(io_wdata, 2); endproperty
a_cmt: assert property (p_cmt) else $error("low byte not from temp");
property p_one; !wide_hi_wr |=> !wide_commit; endproperty
a_one: assert property (p_one) else $error("commit without high write");
property p_rd; wide_lo_rd ##1 wide_hi_rd |=> io_rdata == $past(wide_hi_in, 2); endproperty
a_rd: assert property (p_rd) else $error("high read not from temp");
property p_kio; iok ##1 !(io_wr || mem_wr || nvm_access || sleep_exec) |=> io_change_ok; endproperty
a_kio: assert property (p_kio) else $error("io window not opened");
property p_ksp; spk ##1 !(nvm_access || sleep_exec) |=> selfprog_ok; endproperty
a_ksp: assert property (p_ksp) else $error("selfprog window not opened");
property p_irq; iok || spk |=> irq_hold; endproperty
a_irq: assert property (p_irq) else $error("interrupts not held");
property p_cio; (mem_wr || sleep_exec) && !key |-> ##2 !io_change_ok; endproperty
a_cio: assert property (p_cio) else $error("io window not closed");
property p_csp; (nvm_access || sleep_exec) && !key |-> ##2 !selfprog_ok; endproperty
a_csp: assert property (p_csp) else $error("selfprog window not closed");
property p_grd; io_rd && io_addr == `GUARD_KEY_OFFSET |=> io_rdata[7:2] == 6'h00; endproperty
a_grd: assert property (p_grd) else $error("guard upper bits set");
endmodule
bind cpu_regfile_wide_access_guard cpu_guard_props i_props (.*);

/* File: tb/periph_model.sv */
// Purpose: 16-bit peripheral register on the far side of the byte bus
// Assumes: loads the committed pair, otherwise steps its high byte
// Notes: the stepping high byte exposes any torn read
`timescale 1ns/1ps
module periph_model (
    input wire mclk,
    input wire rst_b,
    input wire wide_commit,
    input wire [7:0] wide_lo_out,
    input wire [7:0] wide_hi_out,
    output wire [7:0] wide_hi_in
);
reg [15:0] val_r;
assign wide_hi_in = val_r[15:8];
always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) val_r <= 16'h0000;
    else if (wide_commit) val_r <= {wide_hi_out, wide_lo_out};
    else val_r <= val_r + 16'h0100;
end
endmodule

/* File: tb/testbench.sv */
// Purpose: directed tests of register file, wide access and change guard
// Assumes: inputs driven on the falling edge
// Notes: strobes held across back-to-back calls
`timescale 1ns/1ps
`include "cpu_guard_regs.vh"
module testbench;
reg mclk = 1'b0;
reg rst_b, res_en, res_wide, ptr_en, ptr_use_c, io_wr, io_rd, insn_done, mem_wr, nvm_access;
reg wide_lo_wr, wide_hi_wr, wide_lo_rd, wide_hi_rd, temp_wr, temp_rd, sleep_exec;
reg [4:0] rd_a_addr, rd_b_addr, res_addr;
reg [1:0] ptr_sel, ptr_mode;
reg [5:0] ptr_disp;
reg [7:0] io_addr, io_wdata, h;
reg [15:0] res_data;
wire [15:0] opnd_a, ptr_addr;
wire [7:0] opnd_b, io_rdata, wide_hi_in, wide_lo_out, wide_hi_out;
wire wide_commit, io_change_ok, selfprog_ok, irq_hold;
integer miscompares = 0;
integer tests_run = 0;
integer i;
cpu_regfile_wide_access_guard i_dut (.*);
periph_model i_periph (.*);
always #2 mclk = ~mclk;
task tick(input integer n);
    repeat (n) @(negedge mclk);
endtask
task chk(input [15:0] seen, input [15:0] exp);
    tests_run = tests_run + 1;
    if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("mismatch %0t saw %h want %h", $time, seen, exp);
    end
endtask
task close_out;
    if (miscompares == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
endtask
task rw(input w, input [4:0] a, input [15:0] d);
    {res_en, res_wide, res_addr, res_data} = {1'b1, w, a, d};
    tick(1);
endtask
task pt(input [1:0] s, input [1:0] m, input [5:0] d, input c, input [15:0] e);
    {ptr_en, ptr_sel, ptr_mode, ptr_disp, ptr_use_c} = {1'b1, s, m, d, c};
    tick(1);
    chk(ptr_addr, e);
endtask
task io(input w, input [7:0] a, input [7:0] d);
    {io_wr, io_rd, io_addr, io_wdata} = {w, !w, a, d};
    tick(1);
endtask
initial begin
    {rst_b, res_en, res_wide, ptr_en, ptr_use_c, io_wr, io_rd, insn_done, mem_wr, nvm_access} = 0;
    {wide_lo_wr, wide_hi_wr, wide_lo_rd, wide_hi_rd, temp_wr, temp_rd, sleep_exec} = 0;
    {rd_a_addr, rd_b_addr, res_addr, ptr_sel, ptr_mode, ptr_disp, io_addr, io_wdata} = 0;
    res_data = 16'h0000;
    tick(12);
    rst_b = 1'b1;
    for (i = 0; i < 32; i = i + 1) rw(1'b0, i[4:0], {8'h00, i[7:0] ^ 8'h5A});
    res_en = 1'b0;
    for (i = 0; i < 32; i = i + 1) begin
        rd_b_addr = i[4:0];
        tick(1);
        chk(opnd_b, i[7:0] ^ 8'h5A);
    end
    rw(1'b1, `PTR_A_LOW, 16'h1234);
    rw(1'b1, `PTR_B_LOW, 16'h0100);
    rw(1'b1, `PTR_C_LOW, 16'hBEEF);
    {res_en, rd_a_addr, rd_b_addr} = {1'b0, `PTR_A_LOW, 5'h1B};
    tick(1);
    chk(opnd_a, 16'h1234);
    chk(opnd_b, 8'h12);
    pt(2'h0, `PTR_MODE_DISP, 6'h3F, 1'b0, 16'h1273);
    pt(2'h0, `PTR_MODE_POSTINC, 6'h00, 1'b0, 16'h1234);
    pt(2'h0, `PTR_MODE_DISP, 6'h00, 1'b0, 16'h1235);
    pt(2'h1, `PTR_MODE_PREDEC, 6'h00, 1'b0, 16'h00FF);
    pt(2'h3, `PTR_MODE_DISP, 6'h01, 1'b0, 16'hBEF0);
    pt(2'h1, `PTR_MODE_DISP, 6'h00, 1'b1, 16'hBEEF);
    {ptr_en, rd_a_addr} = {1'b0, `PTR_B_LOW};
    tick(1);
    chk(opnd_a, 16'h00FF);
    io(1'b0, 8'h1A, 8'h00);
    io_rd = 1'b0;
    chk(io_rdata, 8'h00);
    // no interrupt source here, so the pair is never split
    {wide_lo_wr, io_wdata} = {1'b1, 8'hC4};
    tick(1);
    {wide_lo_wr, wide_hi_wr, io_wdata} = {1'b0, 1'b1, 8'h7E};
    chk(wide_lo_out, 8'h00);
    tick(1);
    wide_hi_wr = 1'b0;
    chk({7'h00, wide_commit, wide_lo_out}, 16'h01C4);
    chk(wide_hi_out, 8'h7E);
    tick(1);
    {h, wide_lo_rd} = {wide_hi_in, 1'b1};
    chk(wide_commit, 1'b0);
    tick(1);
    {wide_lo_rd, wide_hi_rd} = 2'b01;
    tick(1);
    {wide_hi_rd, temp_wr, io_wdata} = {1'b0, 1'b1, 8'h3C};
    chk(io_rdata, h);
    tick(1);
    {temp_wr, temp_rd} = 2'b01;
    tick(1);
    {temp_rd, wide_hi_wr, io_wdata} = {1'b0, 1'b1, 8'h11};
    chk(io_rdata, 8'h3C);
    tick(1);
    wide_hi_wr = 1'b0;
    chk({wide_hi_out, wide_lo_out}, 16'h113C);
    io(1'b1, `GUARD_KEY_OFFSET, 8'h55);
    io_wr = 1'b0;
    tick(2);
    chk({irq_hold, selfprog_ok, io_change_ok}, 0);
    for (i = 0; i < 2; i = i + 1) begin
        io(1'b1, `GUARD_KEY_OFFSET, i ? `SELFPROG_UNLOCK_KEY : `IO_UNLOCK_KEY);
        io_wr = 1'b0;
        chk(irq_hold, 1'b1);
        tick(1);
        chk({selfprog_ok, io_change_ok}, i ? 2 : 1);
        io(1'b0, `GUARD_KEY_OFFSET, 8'h00);
        {io_rd, insn_done} = 2'b01;
        chk(io_rdata, i ? 2 : 1);
        tick(3);
        chk({selfprog_ok, io_change_ok}, i ? 2 : 1);
        chk(irq_hold, 1'b1);
        tick(1);
        insn_done = 1'b0;
        tick(1);
        chk({selfprog_ok, io_change_ok}, 0);
        chk(irq_hold, 1'b0);
    end
    for (i = 0; i < 3; i = i + 1) begin
        io(1'b1, `GUARD_KEY_OFFSET, i == 1 ? `SELFPROG_UNLOCK_KEY : `IO_UNLOCK_KEY);
        io_wr = 1'b0;
        tick(1);
        {sleep_exec, nvm_access, mem_wr} = 3'b001 << i;
        tick(1);
        {sleep_exec, nvm_access, mem_wr} = 3'b000;
        tick(1);
        chk({selfprog_ok, io_change_ok}, 0);
    end
    // the protected write itself is an i/o write and ends the window
    io(1'b1, `GUARD_KEY_OFFSET, `IO_UNLOCK_KEY);
    io(1'b1, 8'h10, 8'h81);
    io_wr = 1'b0;
    chk(io_change_ok, 1'b1);
    tick(1);
    chk(io_change_ok, 1'b0);
    close_out;
end
initial begin
    #20000;
    miscompares = miscompares + 1;
    close_out;
end
endmodule
